// ### rtl/swr_params.svh
// Constants for the single-wire identity reader: timing, codes, CRC.
// Assumes a 100 MHz system clock; included by bare name.
`ifndef SWR_PARAMS_SVH
`define SWR_PARAMS_SVH

`define SWR_CLK_MHZ 100
// ------------------------------------------------------------
// Bus timing in microseconds
// ------------------------------------------------------------
`define SWR_T_RSTL_US 480
`define SWR_T_PRES_US 70
`define SWR_T_RSTH_US 480
`define SWR_T_W1L_US 6
`define SWR_T_W0L_US 60
`define SWR_T_RDL_US 6
`define SWR_T_RDS_US 15
`define SWR_T_SLOT_US 70
`define SWR_T_PROG_US 480
// ------------------------------------------------------------
// Codes and widths
// ------------------------------------------------------------
`define SWR_ID_BITS 64
`define SWR_CRC_RESET 8'h00
`define SWR_CRC_POLY 8'h8C
`define SWR_CMD_RD_ROM 8'hA1
`define SWR_CMD_MATCH_ROM 8'hA2
`define SWR_CMD_SEARCH_ROM 8'hA3
`define SWR_CMD_SKIP_ROM 8'hA4
`define SWR_TIMER_W 17

`endif

// ### rtl/swr_pkg.sv
// Types for the single-wire identity reader.
// Used with full package scope, never imported.
package swr_pkg;

  typedef enum logic [2:0] {
    SWR_OP_RESET = 3'h0,
    SWR_OP_WRITE = 3'h1,
    SWR_OP_READ = 3'h2,
    SWR_OP_IDENT = 3'h3,
    SWR_OP_PROG = 3'h4
  } swr_op_t;

  typedef enum logic [5:0] {
    SWR_ST_IDLE = 6'h01,
    SWR_ST_RSTL = 6'h02,
    SWR_ST_RSTH = 6'h04,
    SWR_ST_BIT = 6'h08,
    SWR_ST_PROG = 6'h10,
    SWR_ST_FIN = 6'h20
  } swr_state_t;

endpackage

// ### rtl/swr_crc8.sv
// Serial CRC-8 accumulator for the identity code.
// Assumes bits are offered one per shift strobe, least significant first.
`timescale 1ns/1ps
`default_nettype none
`include "swr_params.svh"

module swr_crc8 (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic clear_i,
  input wire logic shift_i,
  input wire logic bit_i,
  output logic [7:0] crc_o
);

  logic [7:0] crc_reg;
  logic fb;

  assign fb = bit_i ^ crc_reg[0];
  assign crc_o = crc_reg;

  // Reflected form of x^8+x^5+x^4+1, shifted right
  always_ff @(posedge clk_i) begin
    if (reset_i || clear_i) begin
      crc_reg <= `SWR_CRC_RESET;
    end else if (shift_i) begin
      crc_reg <= {1'b0, crc_reg[7:1]} ^ (fb ? `SWR_CRC_POLY : 8'h00);
    end
  end

endmodule
`default_nettype wire

// ### rtl/swr_host.sv
// Single-wire bus master: bus reset with presence check, byte transfers,
// identity read with CRC check, and programming pulse control.
// Assumes an external open-drain buffer with pull-up on the line and a
// separate programming-voltage switch driven by prog_en_o.
`timescale 1ns/1ps
`default_nettype none
`include "swr_params.svh"

// Contract
// - CRC generator polynomial is x^8 + x^5 + x^4 + 1, shift register form.
// - CRC accumulator is cleared to zero before the first identity bit.
// - Bits enter the CRC one at a time, family code LSB first.
// - After 56 bits the accumulator holds the identity CRC value.
// - Shifting the stored CRC in too leaves zero; that validates the identity.
// - Master opens each transaction with Read, Match, Search or Skip ROM; host refuses only non-ROM writes before one, reads run unchecked.
// - After a ROM command, one of five memory function commands may follow.
// - Every bit travels least significant bit first, both directions.
// - Master programs by normal signalling then a brief programming-level pulse.
module swr_host #(
  parameter int RSTL_CYC = `SWR_T_RSTL_US * `SWR_CLK_MHZ,
  parameter int PRES_CYC = `SWR_T_PRES_US * `SWR_CLK_MHZ,
  parameter int RSTH_CYC = `SWR_T_RSTH_US * `SWR_CLK_MHZ,
  parameter int PROG_CYC = `SWR_T_PROG_US * `SWR_CLK_MHZ,
  parameter int W1L_CYC = `SWR_T_W1L_US * `SWR_CLK_MHZ,
  parameter int W0L_CYC = `SWR_T_W0L_US * `SWR_CLK_MHZ,
  parameter int RDL_CYC = `SWR_T_RDL_US * `SWR_CLK_MHZ,
  parameter int RDS_CYC = `SWR_T_RDS_US * `SWR_CLK_MHZ,
  parameter int SLOT_CYC = `SWR_T_SLOT_US * `SWR_CLK_MHZ
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic cmd_valid_i,
  input wire logic [2:0] cmd_op_i,
  input wire logic [7:0] cmd_data_i,
  output logic cmd_ready_o,
  output logic done_o,
  output logic refused_o,
  output logic presence_o,
  output logic rom_sel_o,
  output logic [7:0] rd_data_o,
  output logic [63:0] ident_o,
  output logic crc_ok_o,
  output logic prog_en_o,
  input wire logic dq_i,
  output logic dq_o,
  output logic dq_oe_n_o
);

  localparam int TW = `SWR_TIMER_W;
  localparam int NB = `SWR_ID_BITS;

  swr_pkg::swr_state_t state_reg;
  logic [TW-1:0] timer_reg;
  logic [NB-1:0] shift_reg;
  logic [NB-1:0] shift_next;
  logic [6:0] bit_cnt_reg;
  logic [6:0] bit_total_reg;
  logic write_reg;
  logic ident_reg;
  logic rom_cmd_reg;
  logic samp_reg;
  logic sync1_reg, sync2_reg, sync3_reg, line_reg;
  logic [TW-1:0] low_len;
  logic slot_end;
  logic last_bit;
  logic is_rom_code;
  logic crc_clear;
  logic crc_shift;
  logic [7:0] crc_val;

  // ------------------------------------------------------------
  // Line input synchroniser
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
      sync3_reg <= 1'b1;
      line_reg <= 1'b1;
    end else begin
      sync1_reg <= dq_i;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      if (sync2_reg == sync3_reg) begin
        line_reg <= sync3_reg;
      end
    end
  end

  // ------------------------------------------------------------
  // Slot decode
  // ------------------------------------------------------------
  assign is_rom_code = (cmd_data_i == `SWR_CMD_RD_ROM) || (cmd_data_i == `SWR_CMD_MATCH_ROM)
    || (cmd_data_i == `SWR_CMD_SEARCH_ROM) || (cmd_data_i == `SWR_CMD_SKIP_ROM);
  assign low_len = !write_reg ? TW'(RDL_CYC) : (shift_reg[0] ? TW'(W1L_CYC) : TW'(W0L_CYC));
  assign slot_end = (state_reg == swr_pkg::SWR_ST_BIT) && (timer_reg == TW'(SLOT_CYC - 1));
  assign last_bit = (bit_cnt_reg == bit_total_reg - 7'h01);
  // Read bits land at the top, so an LSB-first read byte ends in the top eight bits
  assign shift_next = {(write_reg ? 1'b1 : samp_reg), shift_reg[NB-1:1]};

  // ------------------------------------------------------------
  // Identity CRC
  // ------------------------------------------------------------
  assign crc_clear = (state_reg == swr_pkg::SWR_ST_RSTL);
  assign crc_shift = slot_end && ident_reg && !write_reg;

  swr_crc8 u_crc (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .clear_i(crc_clear),
    .shift_i(crc_shift),
    .bit_i(samp_reg),
    .crc_o(crc_val)
  );

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_reg <= swr_pkg::SWR_ST_IDLE;
      timer_reg <= '0;
      shift_reg <= '0;
      bit_cnt_reg <= 7'h00;
      bit_total_reg <= 7'h08;
      write_reg <= 1'b0;
      ident_reg <= 1'b0;
      dq_oe_n_o <= 1'b1;
      prog_en_o <= 1'b0;
    end else begin
      case (state_reg)
        swr_pkg::SWR_ST_IDLE: begin
          timer_reg <= '0;
          if (cmd_valid_i) begin
            case (swr_pkg::swr_op_t'(cmd_op_i))
              swr_pkg::SWR_OP_RESET, swr_pkg::SWR_OP_IDENT: begin
                ident_reg <= (cmd_op_i == swr_pkg::SWR_OP_IDENT);
                dq_oe_n_o <= 1'b0;
                state_reg <= swr_pkg::SWR_ST_RSTL;
              end
              swr_pkg::SWR_OP_WRITE: begin
                ident_reg <= 1'b0;
                if (rom_sel_o || is_rom_code) begin
                  shift_reg <= {56'h0, cmd_data_i};
                  write_reg <= 1'b1;
                  bit_total_reg <= 7'h08;
                  bit_cnt_reg <= 7'h00;
                  dq_oe_n_o <= 1'b0;
                  state_reg <= swr_pkg::SWR_ST_BIT;
                end else begin
                  state_reg <= swr_pkg::SWR_ST_FIN;
                end
              end
              swr_pkg::SWR_OP_READ: begin
                ident_reg <= 1'b0;
                write_reg <= 1'b0;
                bit_total_reg <= 7'h08;
                bit_cnt_reg <= 7'h00;
                dq_oe_n_o <= 1'b0;
                state_reg <= swr_pkg::SWR_ST_BIT;
              end
              swr_pkg::SWR_OP_PROG: begin
                ident_reg <= 1'b0;
                prog_en_o <= 1'b1;
                state_reg <= swr_pkg::SWR_ST_PROG;
              end
              default: begin
                state_reg <= swr_pkg::SWR_ST_FIN;
              end
            endcase
          end
        end
        swr_pkg::SWR_ST_RSTL: begin
          timer_reg <= timer_reg + TW'(1);
          if (timer_reg == TW'(RSTL_CYC - 1)) begin
            dq_oe_n_o <= 1'b1;
            timer_reg <= '0;
            state_reg <= swr_pkg::SWR_ST_RSTH;
          end
        end
        swr_pkg::SWR_ST_RSTH: begin
          timer_reg <= timer_reg + TW'(1);
          if (timer_reg == TW'(RSTH_CYC - 1)) begin
            timer_reg <= '0;
            if (ident_reg && presence_o) begin
              shift_reg <= {56'h0, `SWR_CMD_RD_ROM};
              write_reg <= 1'b1;
              bit_total_reg <= 7'h08;
              bit_cnt_reg <= 7'h00;
              dq_oe_n_o <= 1'b0;
              state_reg <= swr_pkg::SWR_ST_BIT;
            end else begin
              state_reg <= swr_pkg::SWR_ST_FIN;
            end
          end
        end
        swr_pkg::SWR_ST_BIT: begin
          timer_reg <= timer_reg + TW'(1);
          if (timer_reg == low_len - TW'(1)) begin
            dq_oe_n_o <= 1'b1;
          end
          if (slot_end) begin
            timer_reg <= '0;
            shift_reg <= shift_next;
            bit_cnt_reg <= bit_cnt_reg + 7'h01;
            if (!last_bit) begin
              dq_oe_n_o <= 1'b0;
            end else if (ident_reg && write_reg) begin
              // Command byte out, now pull in the whole identity
              write_reg <= 1'b0;
              bit_total_reg <= 7'(NB);
              bit_cnt_reg <= 7'h00;
              dq_oe_n_o <= 1'b0;
            end else begin
              state_reg <= swr_pkg::SWR_ST_FIN;
            end
          end
        end
        swr_pkg::SWR_ST_PROG: begin
          timer_reg <= timer_reg + TW'(1);
          if (timer_reg == TW'(PROG_CYC - 1)) begin
            prog_en_o <= 1'b0;
            state_reg <= swr_pkg::SWR_ST_FIN;
          end
        end
        swr_pkg::SWR_ST_FIN: begin
          state_reg <= swr_pkg::SWR_ST_IDLE;
        end
        default: begin
          dq_oe_n_o <= 1'b1;
          prog_en_o <= 1'b0;
          state_reg <= swr_pkg::SWR_ST_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Sampling and presence
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      samp_reg <= 1'b1;
      presence_o <= 1'b0;
    end else begin
      if (state_reg == swr_pkg::SWR_ST_BIT && timer_reg == TW'(RDS_CYC)) begin
        samp_reg <= line_reg;
      end
      if (state_reg == swr_pkg::SWR_ST_RSTL) begin
        presence_o <= 1'b0;
      end else if (state_reg == swr_pkg::SWR_ST_RSTH && timer_reg == TW'(PRES_CYC)) begin
        presence_o <= !line_reg;
      end
    end
  end

  // ------------------------------------------------------------
  // Results and ROM-level selection state
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      done_o <= 1'b0;
      refused_o <= 1'b0;
      rom_sel_o <= 1'b0;
      rom_cmd_reg <= 1'b0;
      rd_data_o <= 8'h00;
      ident_o <= 64'h0;
      crc_ok_o <= 1'b0;
    end else begin
      done_o <= (state_reg == swr_pkg::SWR_ST_FIN);
      refused_o <= (state_reg == swr_pkg::SWR_ST_IDLE) && cmd_valid_i
        && (cmd_op_i == swr_pkg::SWR_OP_WRITE) && !rom_sel_o && !is_rom_code;
      if (state_reg == swr_pkg::SWR_ST_IDLE && cmd_valid_i) begin
        rom_cmd_reg <= (cmd_op_i == swr_pkg::SWR_OP_WRITE) && is_rom_code;
      end
      if (state_reg == swr_pkg::SWR_ST_RSTL) begin
        rom_sel_o <= 1'b0;
      end else if (state_reg == swr_pkg::SWR_ST_FIN) begin
        if (ident_reg) begin
          // CRC over all 64 bits must come back to zero
          ident_o <= shift_reg;
          crc_ok_o <= presence_o && (crc_val == 8'h00);
          rom_sel_o <= presence_o && (crc_val == 8'h00);
        end else if (rom_cmd_reg && write_reg) begin
          rom_sel_o <= 1'b1;
        end
        if (!write_reg) begin
          rd_data_o <= shift_reg[NB-1:NB-8];
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cmd_ready_o <= 1'b0;
      dq_o <= 1'b0;
    end else begin
      // Ready in idle with no request this cycle, and in the finish state
      cmd_ready_o <= (state_reg == swr_pkg::SWR_ST_IDLE && !cmd_valid_i)
        || (state_reg == swr_pkg::SWR_ST_FIN);
      dq_o <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ### verification/swr_host_props.sv
// Checker for the single-wire host: timing and handshake relations.
// Assumes it is bound to swr_host and sees only its ports.
`timescale 1ns/1ps
`default_nettype none

module swr_host_props #(
  parameter int RSTL_CYC = 48000,
  parameter int PROG_CYC = 48000,
  parameter int W1L_CYC = 600,
  parameter int W0L_CYC = 6000,
  parameter int RDL_CYC = 600
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic cmd_valid_i,
  input wire logic cmd_ready_o,
  input wire logic done_o,
  input wire logic refused_o,
  input wire logic rom_sel_o,
  input wire logic crc_ok_o,
  input wire logic prog_en_o,
  input wire logic dq_o,
  input wire logic dq_oe_n_o
);
  logic [15:0] low_cnt_reg;
  logic [15:0] prog_cnt_reg;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // ----------------------------------------
  // Length counters
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i || dq_oe_n_o) low_cnt_reg <= 16'h0000;
    else low_cnt_reg <= low_cnt_reg + 16'h0001;
  end
  always_ff @(posedge clk_i) begin
    if (reset_i || !prog_en_o) prog_cnt_reg <= 16'h0000;
    else prog_cnt_reg <= prog_cnt_reg + 16'h0001;
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  a_low_width: assert property (
    $rose(dq_oe_n_o) |-> int'(low_cnt_reg) inside {W1L_CYC, W0L_CYC, RDL_CYC, RSTL_CYC})
    else $error("line low time off");
  a_prog_len: assert property (
    $fell(prog_en_o) |-> int'(prog_cnt_reg) == PROG_CYC)
    else $error("programming pulse length off");
  a_refuse_unsel: assert property (refused_o |-> !rom_sel_o)
    else $error("refused while selected");
  a_refuse_quiet: assert property (refused_o |-> dq_oe_n_o && !prog_en_o)
    else $error("line touched on refusal");
  a_refuse_done: assert property (refused_o |=> done_o)
    else $error("no done after refusal");
  a_done_pulse: assert property (done_o |=> !done_o)
    else $error("done longer than one cycle");
  a_take_busy: assert property (cmd_ready_o && cmd_valid_i |=> !cmd_ready_o)
    else $error("ready after take");
  a_drive_zero: assert property (!dq_oe_n_o |-> !dq_o)
    else $error("line driven high");
  a_sel_on_crc: assert property ($rose(crc_ok_o) |-> ##[0:1] rom_sel_o)
    else $error("good identity left unselected");
  c_refused: cover property (refused_o);
  c_crc_good: cover property ($rose(crc_ok_o));
  c_prog: cover property ($fell(prog_en_o));
endmodule

bind swr_host swr_host_props #(.RSTL_CYC(RSTL_CYC), .PROG_CYC(PROG_CYC), .W1L_CYC(W1L_CYC),
  .W0L_CYC(W0L_CYC), .RDL_CYC(RDL_CYC)) u_props (.clk_i(clk_i), .reset_i(reset_i),
  .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o), .done_o(done_o), .refused_o(refused_o),
  .rom_sel_o(rom_sel_o), .crc_ok_o(crc_ok_o), .prog_en_o(prog_en_o), .dq_o(dq_o),
  .dq_oe_n_o(dq_oe_n_o));
`default_nettype wire

// ### verification/swr_dev_model.sv
// Behavioural device on the single wire: presence, byte receive, identity send.
// Assumes a pulled-up line sampled on the host clock.
`timescale 1ns/1ps
`default_nettype none

module swr_dev_model #(
  parameter logic [7:0] MEM_BYTE = 8'hC5
) (
  input wire logic clk_i,
  input wire logic line_i,
  input wire logic present_i,
  input wire logic corrupt_i,
  input wire logic [63:0] ident_i,
  output logic pull_o,
  output logic [7:0] rx_o
);
  logic prev, tx, mem, sel, b, own;
  logic [8:0] lowc;
  logic [7:0] sh;
  logic [3:0] nb;
  logic [6:0] rdn;
  int hold;
  int pdly;
  initial begin
    prev = 1'b1;
    {tx, mem, sel, b, own, pull_o, lowc, sh, nb, rdn, rx_o} = '0;
    hold = 0;
    pdly = 0;
  end
  // ----------------------------------------
  // Slot decode
  // ----------------------------------------
  always @(posedge clk_i) begin
    prev <= line_i;
    lowc <= line_i ? lowc : lowc + 9'h001;
    if (hold == 1) pull_o <= 1'b0;
    if (hold != 0) hold <= hold - 1;
    if (pdly == 1 && present_i) begin
      pull_o <= 1'b1;
      hold <= 80;
    end
    if (pdly != 0) pdly <= pdly - 1;
    if (prev && !line_i) begin
      lowc <= 9'h000;
      // Own presence pulse must not be taken for a host slot
      own <= pull_o;
      if (tx) begin
        b = mem ? MEM_BYTE[rdn[2:0]] : ident_i[rdn[5:0]] ^ (corrupt_i && rdn == 7'h00);
        rdn <= rdn + 7'h01;
        if (!b) begin
          pull_o <= 1'b1;
          hold <= 30;
        end
      end
    end
    if (!prev && line_i && !own) begin
      if (lowc > 9'h096) begin
        {tx, mem, sel, nb} <= '0;
        pdly <= 15;
      end else if (tx) begin
        if (!mem && rdn == 7'h40) begin
          tx <= 1'b0;
          sel <= 1'b1;
        end
      end else begin
        sh = {lowc < 9'h01E, sh[7:1]};
        nb <= nb + 4'h1;
        if (nb == 4'h7) begin
          nb <= 4'h0;
          rx_o <= sh;
          rdn <= 7'h00;
          if (!sel && sh == 8'hA1) tx <= 1'b1;
          else if (!sel && sh inside {8'hA2, 8'hA3, 8'hA4}) sel <= 1'b1;
          else if (sel) {tx, mem} <= 2'b11;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### verification/swr_host_bench.sv
// Self-checking bench for swr_host against the behavioural device.
// Assumes short timing parameters so each identity read with a device present takes ~5500 cycles.
`timescale 1ns/1ps
`default_nettype none

module swr_host_bench;
  localparam logic [7:0] FAM = 8'h5A; // Arbitrary family value
  localparam logic [47:0] SER = 48'h0123_4567_89AB;
  // Short bus timings so a whole identity read stays near 5500 cycles
  localparam int T_RSTL = 200;
  localparam int T_PRES = 60;
  localparam int T_RSTH = 200;
  localparam int T_PROG = 100;
  localparam int T_W1L = 6;
  localparam int T_W0L = 60;
  localparam int T_RDL = 6;
  localparam int T_RDS = 15;
  localparam int T_SLOT = 70;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic cmd_valid_i = 1'b0;
  logic [2:0] cmd_op_i = 3'h0;
  logic [7:0] cmd_data_i = 8'h00;
  logic present = 1'b1;
  logic corrupt = 1'b0;
  logic cmd_ready_o, done_o, refused_o, presence_o, rom_sel_o, crc_ok_o, prog_en_o;
  logic dq_o, dq_oe_n_o, dev_pull, ref_seen;
  logic [7:0] rd_data_o, dev_rx;
  logic [63:0] ident_o, exp_id;
  wire logic line = (dq_oe_n_o | dq_o) & ~dev_pull;
  int miscompares = 0;
  int comparisons = 0;
  int cycles = 0;
  int pcnt;

  always #5 clk_i = ~clk_i;

  swr_host #(.RSTL_CYC(T_RSTL), .PRES_CYC(T_PRES), .RSTH_CYC(T_RSTH), .PROG_CYC(T_PROG),
    .W1L_CYC(T_W1L), .W0L_CYC(T_W0L), .RDL_CYC(T_RDL), .RDS_CYC(T_RDS),
    .SLOT_CYC(T_SLOT)) uut (.clk_i(clk_i),
    .reset_i(reset_i), .cmd_valid_i(cmd_valid_i), .cmd_op_i(cmd_op_i), .cmd_data_i(cmd_data_i),
    .cmd_ready_o(cmd_ready_o), .done_o(done_o), .refused_o(refused_o), .presence_o(presence_o),
    .rom_sel_o(rom_sel_o), .rd_data_o(rd_data_o), .ident_o(ident_o), .crc_ok_o(crc_ok_o),
    .prog_en_o(prog_en_o), .dq_i(line), .dq_o(dq_o), .dq_oe_n_o(dq_oe_n_o));

  swr_dev_model dev (.clk_i(clk_i), .line_i(line), .present_i(present), .corrupt_i(corrupt),
    .ident_i(exp_id), .pull_o(dev_pull), .rx_o(dev_rx));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [7:0] crc8(input logic [55:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < 56; i++) c = (c[0] ^ d[i]) ? ((c >> 1) ^ 8'h8C) : (c >> 1);
    return c;
  endfunction

  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic run_op(input logic [2:0] op, input logic [7:0] d);
    int n;
    n = 0;
    while (cmd_ready_o !== 1'b1) @(posedge clk_i) #1;
    cmd_op_i = op;
    cmd_data_i = d;
    cmd_valid_i = 1'b1;
    @(posedge clk_i) #1;
    cmd_valid_i = 1'b0;
    ref_seen = 1'b0;
    pcnt = 0;
    while (done_o !== 1'b1 && n < 20000) begin
      ref_seen = ref_seen | (refused_o === 1'b1);
      pcnt += int'(prog_en_o === 1'b1);
      n++;
      @(posedge clk_i) #1;
    end
    // A request that never ends counts against the run
    chk("done", 1, done_o);
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 40000) begin
      miscompares++;
      tally_and_finish;
    end
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic sc_presence;
    run_op(3'h0, 8'h00);
    chk("presence", 1, presence_o);
    chk("sel", 0, rom_sel_o);
  endtask

  task automatic sc_refuse;
    run_op(3'h1, 8'hF0);
    chk("refused", 1, ref_seen);
    chk("sel", 0, rom_sel_o);
  endtask

  task automatic sc_rom_codes;
    logic [7:0] codes [4] = '{8'hA1, 8'hA2, 8'hA3, 8'hA4};
    foreach (codes[i]) begin
      run_op(3'h0, 8'h00);
      run_op(3'h1, codes[i]);
      chk("refused", 0, ref_seen);
      chk("sel", 1, rom_sel_o);
      chk("line byte", codes[i], dev_rx);
    end
  endtask

  task automatic sc_mem;
    run_op(3'h0, 8'h00);
    run_op(3'h1, 8'hA4);
    run_op(3'h1, 8'hF0);
    chk("refused", 0, ref_seen);
    chk("line byte", 8'hF0, dev_rx);
    run_op(3'h2, 8'h00);
    chk("read byte", 8'hC5, rd_data_o);
  endtask

  task automatic sc_ident;
    run_op(3'h3, 8'h00);
    chk("ident", exp_id, ident_o);
    chk("crc ok", 1, crc_ok_o);
    chk("sel", 1, rom_sel_o);
  endtask

  task automatic sc_abort;
    run_op(3'h0, 8'h00);
    chk("sel", 0, rom_sel_o);
    run_op(3'h1, 8'hF0);
    chk("refused", 1, ref_seen);
  endtask

  task automatic sc_bad_crc;
    corrupt = 1'b1;
    run_op(3'h3, 8'h00);
    chk("ident", exp_id ^ 64'h1, ident_o);
    chk("crc ok", 0, crc_ok_o);
    corrupt = 1'b0;
  endtask

  task automatic sc_absent;
    present = 1'b0;
    run_op(3'h0, 8'h00);
    chk("presence", 0, presence_o);
    run_op(3'h3, 8'h00);
    chk("crc ok", 0, crc_ok_o);
    present = 1'b1;
  endtask

  task automatic sc_prog;
    run_op(3'h4, 8'h00);
    chk("prog cycles", T_PROG, pcnt);
  endtask

  initial begin
    exp_id = {crc8({SER, FAM}), SER, FAM};
    repeat (16) @(posedge clk_i);
    #1 reset_i = 1'b0;
    sc_presence();
    sc_refuse();
    sc_rom_codes();
    sc_mem();
    sc_ident();
    sc_abort();
    sc_bad_crc();
    sc_absent();
    sc_prog();
    tally_and_finish();
  end
endmodule
`default_nettype wire
